// ### logic/cpm_pkg.sv
// constants for the cpu clock and power manager
package cpm_pkg;
  // register byte offsets
  localparam logic [7:0] CPM_OFS_CPU_SEL = 8'h00;
  localparam logic [7:0] CPM_OFS_BLK_DIS = 8'h04;
  localparam logic [7:0] CPM_OFS_GATE_CTRL = 8'h08;
  localparam logic [7:0] CPM_OFS_THROTTLE = 8'h0C;
  localparam logic [7:0] CPM_OFS_STATUS = 8'h10;
  // per-cpu selection field: source in low two bits, ratio in high two
  localparam int CPM_SEL_W = 4;
  localparam int CPM_SEL_SRC_LSB = 0;
  localparam int CPM_SEL_RATIO_LSB = 2;
  // throttle register fields
  localparam int CPM_THR_QUARTER_BIT = 8;
  // status register fields
  localparam int CPM_ST_THERMAL_BIT = 0;
  localparam int CPM_ST_SEEN_BIT = 1;
  localparam int CPM_ST_THROTTLED_LSB = 8;
  localparam int CPM_ST_BLK_EN_LSB = 16;
  // gate control fields
  localparam int CPM_GATE_AUTO_BIT = 0;
  // reset values
  localparam logic [31:0] CPM_RST_CPU_SEL = 32'h0000_0000;
  localparam logic [31:0] CPM_RST_BLK_DIS = 32'h0000_0000;
  localparam logic CPM_RST_AUTOGATE = 1'b0;
  localparam logic [31:0] CPM_RST_THROTTLE = 32'h0000_0000;
  // clock sources of one cpu
  typedef enum logic [1:0] {
    CPM_SRC_PLL0,
    CPM_SRC_PLL1,
    CPM_SRC_PLL1_DIV,
    CPM_SRC_PLL2_DIV
  } cpm_src_t;
  // divider ratios
  typedef enum logic [1:0] {
    CPM_DIV_1,
    CPM_DIV_2,
    CPM_DIV_4,
    CPM_DIV_RSVD
  } cpm_ratio_t;
  // bus responses
  localparam logic [1:0] CPM_RESP_OKAY = 2'h0;
  localparam logic [1:0] CPM_RESP_DECERR = 2'h3;
endpackage

// ### logic/cpm_top.sv
// cpu clock selection, divider, throttle, block gating and disable mask
//
// How it works
// - idle blocks lose their clock enable
// - dispatched work re-enables clock next cycle
// - each cpu picks pll0 or pll1 directly
// - or an integer-divided pll1 or pll2
// - settings change on pulse boundaries, or between pulses while undivided
// - disable mask register stops unused block clocks
// - disable bits only set, reset alone clears
// - divider offers divide-by-two and divide-by-four
// - thermal interrupt slows selected cpus to at least /2, or to /4
// - throttle release restores clocks within cycles
`timescale 1ns/1ps
`default_nettype none
module cpm_top
  import cpm_pkg::*;
#(
  parameter int NCPU = 4,
  parameter int NBLK = 8,
  parameter int AW = 8
)(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // pll rate ticks, same clock domain
  input wire logic [2:0] pll_tick_i,
  // internal block activity
  input wire logic [NBLK-1:0] block_busy_i,
  input wire logic [NBLK-1:0] block_dispatch_i,
  // external temperature detector, asynchronous
  input wire logic thermal_irq_i,
  // axi4-lite write address
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // generated clock enables
  output logic [NCPU-1:0] cpu_clk_en_o,
  output logic [NBLK-1:0] block_clk_en_o
);

  typedef struct packed {
    logic [NCPU*CPM_SEL_W-1:0] sel;
    logic [NBLK-1:0] block_clock_disable_mask;
    logic autogate;
    logic [NCPU-1:0] thr_sel;
    logic thr_quarter;
    logic [1:0] thr_sync;
    logic thr_prev;
    logic seen;
    logic [NBLK-1:0] blk_en;
    logic [NCPU-1:0][1:0] src;
    logic [NCPU-1:0][1:0] lim;
    logic [NCPU-1:0][1:0] cnt;
    logic [NCPU-1:0] cpu_en;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cpm_state_t;

  cpm_state_t st;
  cpm_state_t next_st;

  logic wr_go;
  logic rd_go;
  logic thermal;
  logic [31:0] wmask;
  logic [NCPU-1:0] throttled;

  // both write channels are taken together, one write at a time
  // handshakes, combinational and held low while the enable is low
  assign wr_go = ce_i & s_axi_awvalid & s_axi_wvalid & ~st.bvalid;
  assign rd_go = ce_i & s_axi_arvalid & ~st.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  // responses and clock enables straight from flops
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign cpu_clk_en_o = st.cpu_en;
  assign block_clk_en_o = st.blk_en;

  assign thermal = st.thr_sync[1];
  assign throttled = thermal ? st.thr_sel : '0;

  always_comb
  begin
    for (int b = 0; b < 4; b++)
    begin
      wmask[b*8 +: 8] = s_axi_wstrb[b] ? 8'hFF : 8'h00;
    end
  end

  // ratio a cpu should run at now, as a divider limit
  function automatic logic [1:0] want_lim(input logic [CPM_SEL_W-1:0] cfg,
                                          input logic thr, input logic quarter);
    logic [1:0] ratio;
    ratio = cfg[CPM_SEL_RATIO_LSB +: 2];
    if (cfg[CPM_SEL_SRC_LSB +: 2] == CPM_SRC_PLL0 || cfg[CPM_SEL_SRC_LSB +: 2] == CPM_SRC_PLL1)
    begin
      ratio = CPM_DIV_1;
    end
    // reserved ratio runs as the slowest one
    if (ratio == CPM_DIV_RSVD)
    begin
      ratio = CPM_DIV_4;
    end
    // throttle: quarter forces /4, otherwise at least /2
    if (thr)
    begin
      if (quarter)
      begin
        ratio = CPM_DIV_4;
      end
      else if (ratio == CPM_DIV_1)
      begin
        ratio = CPM_DIV_2;
      end
    end
    unique case (ratio)
      CPM_DIV_2: want_lim = 2'h1;
      CPM_DIV_4: want_lim = 2'h3;
      CPM_DIV_1, CPM_DIV_RSVD: want_lim = 2'h0;
    endcase
  endfunction

  function automatic logic pick_tick(input logic [1:0] src, input logic [2:0] tick);
    unique case (src)
      CPM_SRC_PLL0: pick_tick = tick[0];
      CPM_SRC_PLL1: pick_tick = tick[1];
      CPM_SRC_PLL1_DIV: pick_tick = tick[1];
      CPM_SRC_PLL2_DIV: pick_tick = tick[2];
    endcase
  endfunction

  always_comb
  begin
    logic [31:0] rd;
    logic [7:0] waddr;
    logic [7:0] raddr;
    logic [CPM_SEL_W-1:0] cfg;
    logic [1:0] cfg_src;
    rd = '0;
    waddr = '0;
    raddr = '0;
    cfg = '0;
    cfg_src = '0;
    next_st = st;

    // thermal input synchroniser and edge capture
    next_st.thr_sync = {st.thr_sync[0], thermal_irq_i};
    next_st.thr_prev = thermal;

    // block clock gating
    for (int i = 0; i < NBLK; i++)
    begin
      next_st.blk_en[i] = ~st.block_clock_disable_mask[i] &
                          (~st.autogate | block_busy_i[i] | block_dispatch_i[i]);
    end

    // per-cpu divider; a new source or ratio is loaded as a pulse is issued,
    // or between pulses while undivided, so the cpu never sees a shortened period
    for (int c = 0; c < NCPU; c++)
    begin
      cfg = st.sel[c*CPM_SEL_W +: CPM_SEL_W];
      cfg_src = cfg[CPM_SEL_SRC_LSB +: 2];
      next_st.cpu_en[c] = 1'b0;
      if (pick_tick(st.src[c], pll_tick_i))
      begin
        if (st.cnt[c] >= st.lim[c])
        begin
          next_st.cpu_en[c] = 1'b1;
          next_st.cnt[c] = 2'h0;
          next_st.src[c] = cfg_src;
          next_st.lim[c] = want_lim(cfg, throttled[c], st.thr_quarter);
        end
        else
        begin
          next_st.cnt[c] = 2'(st.cnt[c] + 2'h1);
        end
      end
      else if (st.lim[c] == 2'h0
               && pick_tick(cfg_src, pll_tick_i) == 1'b0
               && st.src[c] != cfg_src)
      begin
        // idle between full-rate pulses: safe point to switch source
        next_st.src[c] = cfg_src;
        next_st.lim[c] = want_lim(cfg, throttled[c], st.thr_quarter);
      end
    end

    // write channel
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid = 1'b0;
    end
    if (wr_go)
    begin
      waddr = 8'(s_axi_awaddr) & 8'hFC;
      next_st.bvalid = 1'b1;
      next_st.bresp = CPM_RESP_OKAY;
      unique case (waddr)
        CPM_OFS_CPU_SEL:
        begin
          next_st.sel = (NCPU*CPM_SEL_W)'((32'(st.sel) & ~wmask) | (s_axi_wdata & wmask));
        end
        CPM_OFS_BLK_DIS:
        begin
          // bits can only be set; nothing but reset clears them
          next_st.block_clock_disable_mask = st.block_clock_disable_mask |
                                             NBLK'(s_axi_wdata & wmask);
        end
        CPM_OFS_GATE_CTRL:
        begin
          if (s_axi_wstrb[0])
          begin
            next_st.autogate = s_axi_wdata[CPM_GATE_AUTO_BIT];
          end
        end
        CPM_OFS_THROTTLE:
        begin
          if (s_axi_wstrb[0])
          begin
            next_st.thr_sel = NCPU'(s_axi_wdata[7:0]);
          end
          if (s_axi_wstrb[1])
          begin
            next_st.thr_quarter = s_axi_wdata[CPM_THR_QUARTER_BIT];
          end
        end
        CPM_OFS_STATUS:
        begin
          if (s_axi_wstrb[0] && s_axi_wdata[CPM_ST_SEEN_BIT])
          begin
            next_st.seen = 1'b0;
          end
        end
        default:
        begin
          next_st.bresp = CPM_RESP_DECERR;
        end
      endcase
    end
    // a new over-temperature edge wins over a clear in the same cycle
    if (thermal && !st.thr_prev)
    begin
      next_st.seen = 1'b1;
    end

    // read channel
    if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
    end
    if (rd_go)
    begin
      raddr = 8'(s_axi_araddr) & 8'hFC;
      next_st.rvalid = 1'b1;
      next_st.rresp = CPM_RESP_OKAY;
      unique case (raddr)
        CPM_OFS_CPU_SEL: rd = 32'(st.sel);
        CPM_OFS_BLK_DIS: rd = 32'(st.block_clock_disable_mask);
        CPM_OFS_GATE_CTRL: rd[CPM_GATE_AUTO_BIT] = st.autogate;
        CPM_OFS_THROTTLE:
        begin
          rd[NCPU-1:0] = st.thr_sel;
          rd[CPM_THR_QUARTER_BIT] = st.thr_quarter;
        end
        CPM_OFS_STATUS:
        begin
          rd[CPM_ST_THERMAL_BIT] = thermal;
          rd[CPM_ST_SEEN_BIT] = st.seen;
          rd[CPM_ST_THROTTLED_LSB +: NCPU] = throttled;
          rd[CPM_ST_BLK_EN_LSB +: NBLK] = st.blk_en;
        end
        default: next_st.rresp = CPM_RESP_DECERR;
      endcase
      next_st.rdata = rd;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      // programmed registers
      st.sel <= (NCPU*CPM_SEL_W)'(CPM_RST_CPU_SEL);
      st.block_clock_disable_mask <= NBLK'(CPM_RST_BLK_DIS);
      st.autogate <= CPM_RST_AUTOGATE;
      st.thr_sel <= NCPU'(CPM_RST_THROTTLE);
      st.thr_quarter <= 1'b0;
      st.seen <= 1'b0;

      // synchroniser and divider state
      st.thr_sync <= 2'h0;
      st.thr_prev <= 1'b0;
      st.blk_en <= '1;
      st.src <= '0;
      st.lim <= '0;
      st.cnt <= '0;
      st.cpu_en <= '0;

      // bus responses
      st.bvalid <= 1'b0;
      st.bresp <= 2'h0;
      st.rvalid <= 1'b0;
      st.rdata <= 32'h0000_0000;
      st.rresp <= 2'h0;
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end

endmodule // cpm_top
`default_nettype wire

// ### tb/cpm_top_sva.sv
// port assertions for the clock manager
`timescale 1ns/1ps
`default_nettype none
module cpm_top_sva #(
  parameter int NCPU = 4,
  parameter int NBLK = 8
)(
  // watched ports
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [2:0] pll_tick_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [NCPU-1:0] cpu_clk_en_o,
  input wire logic [NBLK-1:0] block_clk_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_pulse_on_tick: assert property (cpu_clk_en_o != 0 |-> $past(pll_tick_i) != 0)
    else $error("cpu pulse without a source tick");
  a_reset_enables: assert property ($rose(rst_b_i) |-> &block_clk_en_o && cpu_clk_en_o == 0)
    else $error("clock enables wrong after reset");
  a_ready_pair: assert property (s_axi_awready == s_axi_wready)
    else $error("write channel readies differ");
  a_no_half_write: assert property (s_axi_awvalid && !s_axi_wvalid |-> !s_axi_awready)
    else $error("address taken without data");
  a_b_latency: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule // cpm_top_sva
`default_nettype wire

// ### tb/cpm_top_tb_top.sv
// self-checking bench for the clock manager
`timescale 1ns/1ps
`default_nettype none
module cpm_top_tb_top;
  import cpm_pkg::*;
  logic clk_i = 0, rst_b_i = 0, ce_i = 1, thermal_irq_i = 0;
  logic [2:0] pll_tick_i = 0;
  logic [7:0] block_busy_i = 0, block_dispatch_i = 0, s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, cpu_clk_en_o;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] block_clk_en_o, m;
  logic [33:0] expq[$];
  logic [1:0] bq[$];
  logic [31:0] sel[2] = '{32'h0000_B610, 32'h0000_FA27};
  int per[2][4] = '{'{2, 3, 6, 20}, '{10, 3, 12, 20}};
  int err_total = 0, tests_run = 0, ph = 0;
  cpm_top cpm_top_inst (.*);
  always #20 clk_i = ~clk_i;
  // pll ticks every 2, 3 and 5 cycles
  always @(posedge clk_i)
  begin
    ph <= (ph + 1) % 30;
    pll_tick_i <= {ph % 5 == 0, ph % 3 == 0, ph % 2 == 0};
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    tests_run++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] %0t seen %h want %h", $time, s, e);
    end
  endtask
  // read results compared while both sides are settled
  always @(negedge clk_i)
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      chk({s_axi_rresp, s_axi_rdata}, expq.pop_front());
  // write responses compared the same way
  always @(negedge clk_i)
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      chk(s_axi_bresp, bq.pop_front());
  task automatic wt(ref logic s);
    int k;
    k = 0;
    @(negedge clk_i);
    while (s !== 1'b1)
    begin
      if (++k > 200)
      begin
        err_total++;
        end_sim;
      end
      @(negedge clk_i);
    end
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] eb = CPM_RESP_OKAY);
    bq.push_back(eb);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    wt(s_axi_awready);
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    repeat (1 + $urandom % 2) @(posedge clk_i);
    s_axi_bready <= 1;
    wt(s_axi_bvalid);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    expq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    wt(s_axi_arready);
    s_axi_arvalid <= 0;
    repeat (1 + $urandom % 2) @(posedge clk_i);
    s_axi_rready <= 1;
    wt(s_axi_rvalid);
    s_axi_rready <= 0;
  endtask
  task automatic rst;
    rst_b_i <= 0;
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1;
  endtask
  // pulses per cpu over a window that every period divides
  task automatic count(input int p[4]);
    int c[4];
    c = '{default: 0};
    repeat (50) @(posedge clk_i);
    repeat (600)
    begin
      @(posedge clk_i);
      #1;
      foreach (c[i]) c[i] += cpu_clk_en_o[i];
    end
    foreach (c[i]) chk(c[i], 600 / p[i]);
  endtask
  initial
  begin
    void'($urandom(32757));
    rst;
    rd(CPM_OFS_CPU_SEL, 0);
    rd(CPM_OFS_STATUS, {8'hFF, 16'h0});
    rd(8'h20, {CPM_RESP_DECERR, 32'h0});
    wr(8'h24, 32'hFFFF_FFFF, CPM_RESP_DECERR);
    m = 8'($urandom);
    wr(CPM_OFS_BLK_DIS, m);
    wr(CPM_OFS_BLK_DIS, 0);
    rd(CPM_OFS_BLK_DIS, m);
    rd(CPM_OFS_STATUS, {~m, 16'h0});
    rst;
    rd(CPM_OFS_BLK_DIS, 0);
    wr(CPM_OFS_GATE_CTRL, 1);
    m = 8'($urandom);
    block_busy_i <= m;
    repeat (2) @(posedge clk_i);
    rd(CPM_OFS_STATUS, {m, 16'h0});
    block_busy_i <= 0;
    repeat (3) @(posedge clk_i);
    block_dispatch_i <= 8'h08;
    @(posedge clk_i);
    block_dispatch_i <= 0;
    #1 chk(block_clk_en_o[3], 1);
    @(posedge clk_i);
    #1 chk(block_clk_en_o, 0);
    wr(CPM_OFS_GATE_CTRL, 0);
    for (int r = 0; r < 2; r++)
    begin
      wr(CPM_OFS_CPU_SEL, sel[r]);
      count(per[r]);
    end
    wr(CPM_OFS_CPU_SEL, 32'h000C);
    wr(CPM_OFS_THROTTLE, 32'h5);
    thermal_irq_i <= 1;
    count('{4, 2, 4, 2});
    rd(CPM_OFS_STATUS, {8'hFF, 8'h05, 8'h03});
    wr(CPM_OFS_THROTTLE, 32'h105);
    count('{8, 2, 8, 2});
    thermal_irq_i <= 0;
    count('{2, 2, 2, 2});
    wr(CPM_OFS_STATUS, 2);
    rd(CPM_OFS_STATUS, {8'hFF, 16'h0});
    end_sim;
  end
endmodule // cpm_top_tb_top
bind cpm_top cpm_top_sva #(.NCPU(NCPU), .NBLK(NBLK)) cpm_top_sva_inst (.*);
`default_nettype wire
